// File: rtl/bmc_top.v
// Brown-out monitor control: mode selection, warning monitor, flags and bus slave
`timescale 1ns/10ps
`include "bmc_regs.vh"

// Functional notes
// - Awake mode: 0 off, 1 continuous, 2 sampled, 3 continuous with wake hold
// - Sleep mode applies in deep sleep: 0 off, 1 continuous, 2 sampled, 3 reserved
// - Level and awake mode from fuses, read-only; sleep mode from fuses, writable
// - Sleep mode write without valid unlock is ignored
// - Deep sleep uses sleep mode; wake returns to awake mode
// - Sampled mode activates detector briefly once per sample period
// - Rate bit 0 selects 1 kHz sampling, 1 selects 125 Hz
// - Three-bit threshold code goes to the analog comparator
// - Warning margin codes 0,1,2 give 5, 15, 25 percent above threshold
// - Trigger codes: 0 falling below, 1 rising above, 2 either crossing
// - Warning monitor off whenever detector disabled; enable bit activates it
// - In sampled mode the warning monitor is evaluated only at samples
// - Warning flag set on configured crossing, never set while detector off (bus clear still works)
// - Interrupt request stays high while flag and enable both set
// - Warning interrupt is withheld while the core halts in debug
// - Supply below threshold while detector active raises system reset
// - Status bit follows comparator only while detector enabled
// - Status reads 1 below warning level, 0 above
module bmc_top
(
  input wire core_clk,
  input wire nrst,
  input wire [3:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  output reg [31:0] avs_readdata,
  output wire avs_waitrequest,
  input wire [1:0] fuse_awake_mode,
  input wire [1:0] fuse_sleep_mode,
  input wire fuse_rate_select,
  input wire [2:0] fuse_level_code,
  input wire fuse_load,
  input wire deep_sleep,
  input wire debug_halt,
  input wire undervoltage_cmp,
  input wire warning_cmp,
  input wire detector_ready,
  output reg detector_enable,
  output reg [2:0] threshold_level_code,
  output reg [1:0] warning_margin_level,
  output reg warning_enable,
  output reg system_reset_req,
  output reg warning_irq,
  output reg core_hold
);

  localparam [31:0] FAST_CYC = `BMC_CLK_HZ / `BMC_RATE_FAST_HZ;
  localparam [31:0] SLOW_CYC = `BMC_CLK_HZ / `BMC_RATE_SLOW_HZ;
  localparam [31:0] PULSE_CYC = `BMC_PULSE_CYC;

  reg [1:0] awake_mode_q;
  reg [1:0] sleep_mode_q;
  reg rate_q;
  reg [2:0] level_q;
  reg [1:0] margin_q;
  reg [1:0] trig_q;
  reg ie_q;
  reg flag_q;
  reg status_q;
  reg [2:0] unlock_q;
  reg [31:0] samp_cnt_q;
  reg [2:0] uv_sync_q;
  reg [2:0] wc_sync_q;
  reg [2:0] rdy_sync_q;
  reg uv_q;
  reg wc_q;
  reg rdy_q;
  reg wc_prev_q;
  reg wc_prev_ok_q;
  reg sleep_prev_q;
  reg hold_q;
  reg bus_ack_q;

  wire [1:0] eff_mode;
  wire det_on;
  wire sampled;
  wire [31:0] period_cyc;
  wire samp_tick;
  wire pulse_on;
  wire eval_now;
  wire crossing;
  wire wr_acc;
  wire rd_acc;
  reg [7:0] rd_byte;

  // ==========================================================
  // Bus slave: one wait cycle for every access
  // ==========================================================
  assign avs_waitrequest = (avs_read | avs_write) & ~bus_ack_q;
  assign wr_acc = avs_write & bus_ack_q & avs_byteenable[0];
  assign rd_acc = avs_read & bus_ack_q;

  // Acknowledge toggles so each access takes exactly two edges
  always @(posedge core_clk)
  begin
    if (!nrst)
      bus_ack_q <= 1'b0;
    else if (bus_ack_q)
      bus_ack_q <= 1'b0;
    else
      bus_ack_q <= avs_read | avs_write;
  end

  // ==========================================================
  // Pin synchronisers: three stages, change accepted when last two agree
  // ==========================================================
  always @(posedge core_clk)
  begin
    if (!nrst)
    begin
      uv_sync_q <= 3'h0;
      wc_sync_q <= 3'h0;
      rdy_sync_q <= 3'h0;
      uv_q <= 1'b0;
      wc_q <= 1'b0;
      rdy_q <= 1'b0;
    end
    else
    begin
      uv_sync_q <= {uv_sync_q[1:0], undervoltage_cmp};
      wc_sync_q <= {wc_sync_q[1:0], warning_cmp};
      rdy_sync_q <= {rdy_sync_q[1:0], detector_ready};
      if (uv_sync_q[1] == uv_sync_q[2])
        uv_q <= uv_sync_q[2];
      if (wc_sync_q[1] == wc_sync_q[2])
        wc_q <= wc_sync_q[2];
      if (rdy_sync_q[1] == rdy_sync_q[2])
        rdy_q <= rdy_sync_q[2];
    end
  end

  // ==========================================================
  // Mode selection and sampling
  // ==========================================================
  // Deep sleep uses the sleep field, otherwise the awake field
  assign eff_mode = deep_sleep ? sleep_mode_q : awake_mode_q;
  assign det_on = (eff_mode != `BMC_MODE_OFF) && !(deep_sleep && eff_mode == `BMC_MODE_HALT);
  assign sampled = (eff_mode == `BMC_MODE_SAMP);
  assign period_cyc = rate_q ? SLOW_CYC : FAST_CYC;
  assign samp_tick = sampled && (samp_cnt_q == period_cyc - 32'h1);
  assign pulse_on = sampled && (samp_cnt_q < PULSE_CYC);
  // Warning evaluated at the end of each sample pulse when sampled
  assign eval_now = det_on && (!sampled || samp_cnt_q == PULSE_CYC - 32'h1);

  // Sample period counter
  always @(posedge core_clk)
  begin
    if (!nrst || !sampled || samp_tick)
      samp_cnt_q <= 32'h0;
    else
      samp_cnt_q <= samp_cnt_q + 32'h1;
  end

  // Drive the analog side
  always @(posedge core_clk)
  begin
    if (!nrst)
    begin
      detector_enable <= 1'b0;
      threshold_level_code <= 3'h0;
      warning_margin_level <= `BMC_MARGIN_RST;
      warning_enable <= 1'b0;
    end
    else
    begin
      detector_enable <= det_on && (!sampled || pulse_on);
      threshold_level_code <= level_q;
      warning_margin_level <= margin_q;
      warning_enable <= det_on && ie_q && (!sampled || pulse_on);
    end
  end

  // ==========================================================
  // Fuse-loaded fields and unlock window
  // ==========================================================
  always @(posedge core_clk)
  begin
    if (!nrst)
    begin
      awake_mode_q <= `BMC_MODE_OFF;
      sleep_mode_q <= `BMC_MODE_OFF;
      rate_q <= 1'b0;
      level_q <= 3'h0;
      unlock_q <= 3'h0;
    end
    else if (fuse_load)
    begin
      awake_mode_q <= fuse_awake_mode;
      sleep_mode_q <= fuse_sleep_mode;
      rate_q <= fuse_rate_select;
      level_q <= fuse_level_code;
      unlock_q <= 3'h0;
    end
    else
    begin
      // Key opens a window counted down once every core clock cycle, not per bus access
      if (wr_acc && avs_address == `BMC_IDX_UNLOCK && avs_writedata[7:0] == `BMC_UNLOCK_KEY)
        unlock_q <= `BMC_UNLOCK_WIN;
      else if (unlock_q != 3'h0)
        unlock_q <= unlock_q - 3'h1;
      if (wr_acc && avs_address == `BMC_IDX_MODE && unlock_q != 3'h0)
        sleep_mode_q <= avs_writedata[`BMC_SLEEP_LSB +: 2];
    end
  end

  // ==========================================================
  // Warning control registers
  // ==========================================================
  always @(posedge core_clk)
  begin
    if (!nrst)
    begin
      margin_q <= `BMC_MARGIN_RST;
      trig_q <= 2'h0;
      ie_q <= 1'b0;
    end
    else if (wr_acc)
    begin
      if (avs_address == `BMC_IDX_MARGIN)
        margin_q <= avs_writedata[1:0];
      else if (avs_address == `BMC_IDX_WARNING_INTERRUPT_CONTROL)
      begin
        trig_q <= avs_writedata[`BMC_TRIG_LSB +: 2];
        ie_q <= avs_writedata[`BMC_IE_BIT];
      end
    end
  end

  // ==========================================================
  // Warning monitor: status, crossing detection, flag
  // ==========================================================
  assign crossing = eval_now && ie_q && wc_prev_ok_q && (
    (trig_q == `BMC_TRIG_BELOW && wc_q && !wc_prev_q) ||
    (trig_q == `BMC_TRIG_ABOVE && !wc_q && wc_prev_q) ||
    (trig_q == `BMC_TRIG_CROSS && wc_q != wc_prev_q));

  // Status and previous sample, held while detector is off
  always @(posedge core_clk)
  begin
    if (!nrst)
    begin
      status_q <= 1'b0;
      wc_prev_q <= 1'b0;
      wc_prev_ok_q <= 1'b0;
    end
    else if (!det_on)
      wc_prev_ok_q <= 1'b0;
    else if (eval_now)
    begin
      status_q <= wc_q;
      wc_prev_q <= wc_q;
      wc_prev_ok_q <= 1'b1;
    end
  end

  // Flag: set wins over clear, never set while detector off; bus clear still works
  always @(posedge core_clk)
  begin
    if (!nrst)
      flag_q <= 1'b0;
    else if (crossing && det_on)
      flag_q <= 1'b1;
    else if (wr_acc && avs_address == `BMC_IDX_FLAGS && avs_writedata[0])
      flag_q <= 1'b0;
  end

  // Interrupt request, withheld during debug halt
  always @(posedge core_clk)
  begin
    if (!nrst)
      warning_irq <= 1'b0;
    else
      warning_irq <= flag_q && ie_q && !debug_halt;
  end

  // ==========================================================
  // System reset request and wake hold
  // ==========================================================
  always @(posedge core_clk)
  begin
    if (!nrst)
      system_reset_req <= 1'b0;
    else
      system_reset_req <= det_on && (!sampled || eval_now) && uv_q;
  end

  // Hold the core from wake in awake mode 3 until the detector reports running
  always @(posedge core_clk)
  begin
    if (!nrst)
    begin
      sleep_prev_q <= 1'b0;
      hold_q <= 1'b0;
      core_hold <= 1'b0;
    end
    else
    begin
      sleep_prev_q <= deep_sleep;
      if (sleep_prev_q && !deep_sleep && awake_mode_q == `BMC_MODE_HALT)
        hold_q <= 1'b1;
      else if (rdy_q || deep_sleep)
        hold_q <= 1'b0;
      core_hold <= hold_q && !rdy_q;
    end
  end

  // ==========================================================
  // Read data
  // ==========================================================
  always @*
  begin
    rd_byte = 8'h00;
    if (avs_address == `BMC_IDX_MODE)
      rd_byte = {3'h0, rate_q, awake_mode_q, sleep_mode_q};
    else if (avs_address == `BMC_IDX_LEVEL)
      rd_byte = {5'h00, level_q};
    else if (avs_address == `BMC_IDX_MARGIN)
      rd_byte = {6'h00, margin_q};
    else if (avs_address == `BMC_IDX_WARNING_INTERRUPT_CONTROL)
      rd_byte = {5'h00, trig_q, ie_q};
    else if (avs_address == `BMC_IDX_FLAGS)
      rd_byte = {7'h00, flag_q};
    else if (avs_address == `BMC_IDX_STATUS)
      rd_byte = {7'h00, status_q};
  end

  // Registered read data, presented when waitrequest drops
  always @(posedge core_clk)
  begin
    if (!nrst)
      avs_readdata <= 32'h0;
    else if (avs_read && !bus_ack_q)
      avs_readdata <= {24'h0, rd_byte};
  end

endmodule

// File: rtl/bmc_regs.vh
// Register offsets, field positions, reset values and timing counts of the brown-out monitor control
`ifndef BMC_REGS_VH
`define BMC_REGS_VH
// Register indices; byte address is four times the index
`define BMC_IDX_MODE 4'h0
`define BMC_IDX_LEVEL 4'h1
`define BMC_IDX_MARGIN 4'h8
`define BMC_IDX_WARNING_INTERRUPT_CONTROL 4'h9
`define BMC_IDX_FLAGS 4'hA
`define BMC_IDX_STATUS 4'hB
`define BMC_IDX_UNLOCK 4'hC
// Field positions
`define BMC_SLEEP_LSB 0
`define BMC_AWAKE_LSB 2
`define BMC_RATE_BIT 4
`define BMC_TRIG_LSB 1
`define BMC_IE_BIT 0
// Mode encodings
`define BMC_MODE_OFF 2'h0
`define BMC_MODE_CONT 2'h1
`define BMC_MODE_SAMP 2'h2
`define BMC_MODE_HALT 2'h3
// Trigger encodings
`define BMC_TRIG_BELOW 2'h0
`define BMC_TRIG_ABOVE 2'h1
`define BMC_TRIG_CROSS 2'h2
// Reset values
`define BMC_MARGIN_RST 2'h0
`define BMC_WARNING_INTERRUPT_CONTROL_RST 3'h0
// Unlock key and window
`define BMC_UNLOCK_KEY 8'hD8
`define BMC_UNLOCK_WIN 3'h4
// Timing: core rate and sample periods
`define BMC_CLK_HZ 250000000
`define BMC_RATE_FAST_HZ 1000
`define BMC_RATE_SLOW_HZ 125
`define BMC_PULSE_NS 40
`define BMC_CLK_NS 4
`define BMC_PULSE_CYC ((`BMC_PULSE_NS + `BMC_CLK_NS - 1) / `BMC_CLK_NS)
`endif

// File: sim/bmc_top_monitor.sv
// Port assertions for the brown-out monitor control
`timescale 1ns/10ps
`include "bmc_regs.vh"
module bmc_top_monitor
(
  input wire core_clk,
  input wire nrst,
  input wire [3:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  input wire [31:0] avs_readdata,
  input wire avs_waitrequest,
  input wire [2:0] fuse_level_code,
  input wire fuse_load,
  input wire debug_halt,
  input wire undervoltage_cmp,
  input wire detector_ready,
  input wire [2:0] threshold_level_code,
  input wire [1:0] warning_margin_level,
  input wire system_reset_req,
  input wire warning_irq,
  input wire core_hold
);
  // ====================
  // Clocking, completed accesses and bus steps
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!nrst);
  wire wr_done = avs_write && !avs_waitrequest && avs_byteenable[0];
  wire rd_done = avs_read && !avs_waitrequest;
  sequence req_s;
    $rose(avs_read || avs_write);
  endsequence
  sequence ack_s;
    avs_waitrequest ##1 !avs_waitrequest;
  endsequence
  // Port relations
  wait_state_a: assert property (req_s |-> ack_s)
    else $error("bus wait state wrong");
  level_load_a: assert property ($past(fuse_load) |-> ##[0:1] threshold_level_code == fuse_level_code)
    else $error("threshold code not taken from fuse");
  level_read_a: assert property (rd_done && avs_address == `BMC_IDX_LEVEL |-> avs_readdata == {29'h0, threshold_level_code})
    else $error("level register read wrong");
  margin_out_a: assert property (wr_done && avs_address == `BMC_IDX_MARGIN |-> ##2 warning_margin_level == $past(avs_writedata[1:0], 2))
    else $error("margin output not updated");
  irq_hold_a: assert property (warning_irq && !debug_halt && !wr_done && !$past(wr_done) |=> warning_irq)
    else $error("interrupt dropped without clear");
  dbg_mask_a: assert property (debug_halt && $past(debug_halt) |-> !warning_irq)
    else $error("interrupt raised during debug halt");
  reset_quiet_a: assert property (!undervoltage_cmp [*8] |-> !system_reset_req)
    else $error("reset request without undervoltage");
  hold_release_a: assert property (detector_ready [*8] |-> !core_hold)
    else $error("core held while detector ready");
endmodule
bind bmc_top bmc_top_monitor mon (.*);

// File: sim/bmc_analog.sv
// Analog comparator pair and reset-time fuse loader model
`timescale 1ns/10ps
module bmc_analog
(
  input wire core_clk,
  input wire nrst,
  input wire detector_enable,
  input wire uv_in,
  input wire warn_in,
  output reg fuse_load,
  output reg undervoltage_cmp,
  output reg warning_cmp,
  output reg detector_ready
);
  reg [1:0] boot_q;
  initial {fuse_load, undervoltage_cmp, warning_cmp, detector_ready} = 4'h0;
  // ====================
  // Fuse strobe once after reset; comparators report even when unpowered
  always @(posedge core_clk)
  begin
    boot_q <= nrst ? {boot_q[0], 1'b1} : 2'h0;
    fuse_load <= nrst && boot_q == 2'h1;
    undervoltage_cmp <= uv_in;
    warning_cmp <= warn_in;
    detector_ready <= detector_enable;
  end
endmodule

// File: sim/brownout_monitor_control_tb.sv
// Self-checking bench for the brown-out monitor control
`timescale 1ns/10ps
`include "bmc_regs.vh"
module brownout_monitor_control_tb;
  reg core_clk = 0, nrst = 0, avs_read = 0, avs_write = 0;
  reg deep_sleep = 0, debug_halt = 0, uv_in = 0, warn_in = 0;
  reg [3:0] avs_address = 4'h0;
  reg [31:0] avs_writedata = 32'h0;
  reg [7:0] rd;
  wire [31:0] avs_readdata;
  wire [2:0] threshold_level_code;
  wire [1:0] warning_margin_level;
  wire avs_waitrequest, fuse_load, uv_cmp, warn_cmp, ready, det_en;
  wire system_reset_req, warning_irq, core_hold;
  integer err_count = 0, checks = 0, cyc = 0, i;
  // ====================
  // Clock, timeout and instances
  always #2 core_clk = ~core_clk;
  always @(posedge core_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      err_count = err_count + 1;
      conclude;
    end
  end
  bmc_top dut (.core_clk(core_clk), .nrst(nrst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'h1), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .fuse_awake_mode(2'h1), .fuse_sleep_mode(2'h2), .fuse_rate_select(1'b1),
    .fuse_level_code(3'h7), .fuse_load(fuse_load), .deep_sleep(deep_sleep), .debug_halt(debug_halt),
    .undervoltage_cmp(uv_cmp), .warning_cmp(warn_cmp), .detector_ready(ready), .detector_enable(det_en),
    .threshold_level_code(threshold_level_code), .warning_margin_level(warning_margin_level), .warning_enable(),
    .system_reset_req(system_reset_req), .warning_irq(warning_irq), .core_hold(core_hold));
  bmc_analog ana (.core_clk(core_clk), .nrst(nrst), .detector_enable(det_en), .uv_in(uv_in), .warn_in(warn_in),
    .fuse_load(fuse_load), .undervoltage_cmp(uv_cmp), .warning_cmp(warn_cmp), .detector_ready(ready));
  // Verdict
  task conclude;
  begin
    $display("Comparisons %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  end
  endtask
  // Compare one byte
  task chk(input [63:0] n, input [7:0] e, input [7:0] s);
  begin
    checks = checks + 1;
    if (s !== e)
    begin
      err_count = err_count + 1;
      $display("ERROR %0s expected %h seen %h", n, e, s);
    end
  end
  endtask
  // One bus access, held until waitrequest is seen low at a rising edge
  task bus(input w, input [3:0] a, input [7:0] d);
  begin
    avs_address <= a;
    avs_writedata <= {24'h0, d};
    avs_write <= w;
    avs_read <= !w;
    @(posedge core_clk);
    while (avs_waitrequest !== 1'b0)
      @(posedge core_clk);
    // Completing edge: read data taken here, request released after it
    rd = avs_readdata[7:0];
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge core_clk);
  end
  endtask
  task rdc(input [3:0] a, input [7:0] e);
  begin
    bus(1'b0, a, 8'h00);
    chk("regread", e, rd);
  end
  endtask
  task pause;
  begin
    repeat (10) @(posedge core_clk);
  end
  endtask
  // ====================
  // Scenarios
  task t_fuse;
  begin
    rdc(`BMC_IDX_MODE, 8'h16);
    rdc(`BMC_IDX_LEVEL, 8'h07);
    chk("level", 8'h07, {5'h0, threshold_level_code});
    bus(1'b1, `BMC_IDX_MODE, 8'h01);
    rdc(`BMC_IDX_MODE, 8'h16);
    bus(1'b1, `BMC_IDX_LEVEL, 8'h02);
    rdc(`BMC_IDX_LEVEL, 8'h07);
    rdc(`BMC_IDX_WARNING_INTERRUPT_CONTROL, 8'h00);
    rdc(`BMC_IDX_FLAGS, 8'h00);
    rdc(4'h5, 8'h00);
    chk("hold", 8'h00, {7'h0, core_hold});
  end
  endtask
  task t_margin;
  begin
    rdc(`BMC_IDX_MARGIN, 8'h00);
    for (i = 0; i < 3; i = i + 1)
    begin
      bus(1'b1, `BMC_IDX_MARGIN, i[7:0]);
      rdc(`BMC_IDX_MARGIN, i[7:0]);
      chk("margin", i[7:0], {6'h0, warning_margin_level});
    end
  end
  endtask
  task t_sleep;
  begin
    bus(1'b1, `BMC_IDX_UNLOCK, `BMC_UNLOCK_KEY);
    bus(1'b1, `BMC_IDX_MODE, 8'h00);
    rdc(`BMC_IDX_MODE, 8'h14);
    bus(1'b1, `BMC_IDX_WARNING_INTERRUPT_CONTROL, 8'h05);
    deep_sleep <= 1'b1;
    pause;
    uv_in <= 1'b1;
    warn_in <= 1'b1;
    pause;
    chk("detect", 8'h00, {7'h0, det_en});
    chk("sysreset", 8'h00, {7'h0, system_reset_req});
    chk("irq", 8'h00, {7'h0, warning_irq});
    warn_in <= 1'b0;
    pause;
    deep_sleep <= 1'b0;
    pause;
    chk("detect", 8'h01, {7'h0, det_en});
    chk("sysreset", 8'h01, {7'h0, system_reset_req});
    uv_in <= 1'b0;
    pause;
    chk("sysreset", 8'h00, {7'h0, system_reset_req});
  end
  endtask
  task trig(input [7:0] ctl, input lvl, input exp);
  begin
    bus(1'b1, `BMC_IDX_WARNING_INTERRUPT_CONTROL, ctl);
    pause;
    warn_in <= lvl;
    pause;
    chk("irq", {7'h0, exp}, {7'h0, warning_irq});
    rdc(`BMC_IDX_STATUS, {7'h0, lvl});
    bus(1'b1, `BMC_IDX_FLAGS, 8'h01);
    // Request drops one edge after the clear lands
    @(posedge core_clk);
    chk("irq", 8'h00, {7'h0, warning_irq});
  end
  endtask
  task t_dbg;
  begin
    bus(1'b1, `BMC_IDX_WARNING_INTERRUPT_CONTROL, 8'h01);
    warn_in <= 1'b0;
    pause;
    warn_in <= 1'b1;
    pause;
    bus(1'b1, `BMC_IDX_FLAGS, 8'h00);
    chk("irq", 8'h01, {7'h0, warning_irq});
    debug_halt <= 1'b1;
    pause;
    chk("irq", 8'h00, {7'h0, warning_irq});
    debug_halt <= 1'b0;
    pause;
    chk("irq", 8'h01, {7'h0, warning_irq});
    bus(1'b1, `BMC_IDX_FLAGS, 8'h01);
    rdc(`BMC_IDX_FLAGS, 8'h00);
  end
  endtask
  // ====================
  // Main sequence
  initial
  begin
    repeat (2) @(posedge core_clk);
    nrst <= 1'b1;
    repeat (6) @(posedge core_clk);
    t_fuse;
    t_margin;
    t_sleep;
    trig(8'h01, 1'b1, 1'b1);
    trig(8'h01, 1'b0, 1'b0);
    trig(8'h03, 1'b1, 1'b0);
    trig(8'h03, 1'b0, 1'b1);
    trig(8'h05, 1'b1, 1'b1);
    trig(8'h05, 1'b0, 1'b1);
    trig(8'h00, 1'b1, 1'b0);
    t_dbg;
    conclude;
  end
endmodule
